// ==== rtl/dcr_pkg.sv ====
package dcr_pkg;
    localparam int CLK_MHZ      = 100;
    localparam int SMP_BASE_US  = 20;
    localparam int SMP_BASE_CYC = SMP_BASE_US * CLK_MHZ;
    localparam int BLINK_MS     = 250;
    localparam int BLINK_CYC    = BLINK_MS * 1000 * CLK_MHZ;
    localparam int LOG_DEPTH    = 2000;
    localparam int AVG_MAX      = 1000;
    localparam int NCH          = 2;

    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_MASK = 8'h08;
    localparam logic [7:0] A_LIDX = 8'h0C;
    localparam logic [7:0] A_LDAT = 8'h10;
    localparam logic [7:0] A_LCNT = 8'h14;
    localparam logic [1:0] A_CHBLK = 2'h1;
    localparam logic [2:0] S_CFG  = 3'h0;
    localparam logic [2:0] S_CAL  = 3'h1;
    localparam logic [2:0] S_CLIP = 3'h2;
    localparam logic [2:0] S_AVG  = 3'h3;
    localparam logic [2:0] S_DATA = 3'h4;
    localparam logic [2:0] S_PEAK = 3'h5;

    localparam int C_RUN  = 0;
    localparam int C_SMP  = 1;
    localparam int C_TRIG = 3;
    localparam int C_EDGE = 4;
    localparam int C_LOG  = 6;
    localparam int F_RNG  = 0;
    localparam int F_AVG  = 3;
    localparam int F_FLT  = 5;
    localparam int F_K1   = 8;
    localparam int F_K2   = 12;
    localparam int F_N    = 0;
    localparam int F_RCP  = 15;
    localparam int LI_CH  = 11;
    localparam int ST_LIM  = 0;
    localparam int ST_DISC = 2;
    localparam int ST_TRIG = 4;
    localparam int ST_DATA = 6;
    localparam int ST_W    = 7;
    localparam int GAIN_SH = 14;

    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CFG_RST  = 32'h0000_0000;
    localparam logic [31:0] CAL_RST  = 32'h0000_4000;
    localparam logic [31:0] CLIP_RST = 32'h7FFF_8000;
    localparam logic [31:0] AVG_RST  = 32'h8000_0001;
    localparam logic [15:0] PEAK_RST = 16'h8000;
    localparam logic [9:0]  AVG_MAXN = 10'h3E8;

    localparam logic signed [16:0] LIM_HI     = 17'h0_7E80;
    localparam logic signed [16:0] LIM_LO_BI  = 17'h1_8180;
    localparam logic signed [16:0] LIM_LO_UNI = 17'h1_FE80;

    typedef enum logic [2:0] {
        RNG_V10B  = 3'b000, RNG_V10U  = 3'b001, RNG_V5B   = 3'b010,
        RNG_V5U   = 3'b011, RNG_V1_5  = 3'b100, RNG_MA20B = 3'b101,
        RNG_MA20U = 3'b110, RNG_MA4   = 3'b111
    } dcr_range_e;
    typedef enum logic [1:0] {
        AVG_OFF = 2'b00, AVG_TIME = 2'b01, AVG_MOV = 2'b10, AVG_RSV = 2'b11
    } dcr_avg_e;
    typedef enum logic [1:0] {
        FLT_OFF = 2'b00, FLT_LP = 2'b01, FLT_BP = 2'b10, FLT_RSV = 2'b11
    } dcr_flt_e;
endpackage

// ==== rtl/dcr_chan_if.sv ====
interface dcr_chan_if;
    import dcr_pkg::*;
    logic               smp_v;
    logic               clr;
    logic signed [16:0] code;
    logic               hi;
    logic               lo;
    logic [31:0]        cfg;
    logic [31:0]        cal;
    logic [31:0]        clip;
    logic [31:0]        avg;
    logic               res_v;
    logic signed [15:0] res;
    logic               lim_ev;
    logic               disc_ev;
    modport host (output smp_v, clr, code, hi, lo, cfg, cal, clip, avg,
                  input res_v, res, lim_ev, disc_ev);
    modport chan (input smp_v, clr, code, hi, lo, cfg, cal, clip, avg,
                  output res_v, res, lim_ev, disc_ev);
endinterface

// ==== rtl/dcr_chan.sv ====
module dcr_chan
    import dcr_pkg::*;
#(
    parameter int AVG_DEPTH = AVG_MAX
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    dcr_chan_if.chan cb
);
    dcr_range_e rng;
    dcr_avg_e   amode;
    dcr_flt_e   fmode;
    assign rng   = dcr_range_e'(cb.cfg[F_RNG +: 3]);
    assign amode = dcr_avg_e'(cb.cfg[F_AVG +: 2]);
    assign fmode = dcr_flt_e'(cb.cfg[F_FLT +: 2]);
    wire [3:0] k1 = cb.cfg[F_K1 +: 4];
    wire [3:0] k2 = cb.cfg[F_K2 +: 4];

    wire uni = rng inside {RNG_V10U, RNG_V5U, RNG_V1_5, RNG_MA20U, RNG_MA4};
    wire disc_en = (rng == RNG_V1_5) || (rng == RNG_MA4);          // R9
    wire signed [16:0] lo_lim = uni ? LIM_LO_UNI : LIM_LO_BI;       // R10
    wire over  = cb.hi || (cb.code > LIM_HI);                       // R11
    wire under = cb.lo || (cb.code < lo_lim);                       // R11
    wire signed [16:0] clmp = over ? LIM_HI : (under ? lo_lim : cb.code); // R10

    logic signed [16:0] x_q;
    logic               x_v_q, lim_q, disc_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            x_q    <= '0;
            x_v_q  <= 1'b0;
            lim_q  <= 1'b0;
            disc_q <= 1'b0;
        end else begin
            x_v_q  <= cb.smp_v;
            lim_q  <= cb.smp_v && (over || under);  // R10
            disc_q <= cb.smp_v && disc_en && cb.lo; // R9
            if (cb.smp_v) x_q <= clmp;
        end
    end

    // software gives 1/n as a q16 reciprocal, so no divider
    wire [9:0] n_raw = cb.avg[F_N +: 10];
    wire [9:0] n = (n_raw == 10'h000) ? 10'h001 :
                   (n_raw > AVG_MAXN) ? AVG_MAXN : n_raw;
    wire [16:0] rcp = cb.avg[F_RCP +: 17];
    logic signed [25:0] acc_q, sum_q;
    logic [9:0]         cnt_q, wp_q, fill_q;
    logic signed [16:0] ring [AVG_DEPTH];
    wire full = (fill_q >= n);
    wire signed [25:0] xw    = 26'(x_q);
    wire signed [25:0] old   = full ? 26'(ring[wp_q]) : 26'h000_0000;
    wire signed [25:0] acc_n = acc_q + xw;
    wire signed [25:0] sum_n = sum_q + xw - old;
    wire last = (cnt_q + 10'h001) >= n;
    wire signed [25:0] avin  = (amode == AVG_MOV) ? sum_n : acc_n;
    wire signed [43:0] aprod = avin * $signed({1'b0, rcp});
    wire signed [17:0] a_d   = (amode == AVG_TIME || amode == AVG_MOV) ?
                               aprod[33:16] : 18'(x_q);
    wire a_fire = x_v_q && ((amode != AVG_TIME) || last);      // R3
    wire [9:0] wp_n = (wp_q + 10'h001 >= n) ? 10'h000 : wp_q + 10'h001;

    logic signed [17:0] a_q;
    logic               a_v_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            acc_q  <= '0;
            sum_q  <= '0;
            cnt_q  <= '0;
            wp_q   <= '0;
            fill_q <= '0;
            a_q    <= '0;
            a_v_q  <= 1'b0;
        end else if (cb.clr) begin
            acc_q  <= '0;
            sum_q  <= '0;
            cnt_q  <= '0;
            wp_q   <= '0;
            fill_q <= '0;
            a_v_q  <= 1'b0;
        end else begin
            a_v_q <= a_fire;
            if (a_fire) a_q <= a_d;
            if (x_v_q && amode == AVG_TIME) begin // R3
                acc_q <= last ? 26'h000_0000 : acc_n;
                cnt_q <= last ? 10'h000 : cnt_q + 10'h001;
            end
            if (x_v_q && amode == AVG_MOV) begin  // R3
                sum_q  <= sum_n;
                wp_q   <= wp_n;
                fill_q <= full ? fill_q : fill_q + 10'h001;
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (x_v_q && amode == AVG_MOV) ring[wp_q] <= x_q;
    end

    // band-pass is fast low-pass minus slow low-pass
    logic signed [17:0] lp1_q, lp2_q, f_q;
    logic               f_v_q;
    wire signed [17:0] d1 = lp1_q + ((a_q - lp1_q) >>> k1);
    wire signed [17:0] d2 = lp2_q + ((a_q - lp2_q) >>> k2);
    wire signed [17:0] f_d = (fmode == FLT_LP) ? d1 :
                             (fmode == FLT_BP) ? d1 - d2 : a_q;  // R4
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lp1_q <= '0;
            lp2_q <= '0;
            f_q   <= '0;
            f_v_q <= 1'b0;
        end else begin
            f_v_q <= a_v_q;
            if (a_v_q) begin
                lp1_q <= d1;
                lp2_q <= d2;
                f_q   <= f_d;
            end
        end
    end

    // calibration last
    wire signed [34:0] gp   = f_q * $signed({1'b0, cb.cal[15:0]}); // R6
    wire signed [20:0] gs   = gp[34:GAIN_SH];
    wire signed [21:0] co   = 22'(gs) + 22'($signed(cb.cal[31:16])); // R6
    wire signed [15:0] cmax = cb.clip[31:16];
    wire signed [15:0] cmin = cb.clip[15:0];
    wire signed [15:0] cv   = (co > 22'(cmax)) ? cmax :
                              (co < 22'(cmin)) ? cmin : co[15:0]; // R6
    logic signed [15:0] res_q;
    logic               res_v_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            res_q   <= '0;
            res_v_q <= 1'b0;
        end else begin
            res_v_q <= f_v_q;
            if (f_v_q) res_q <= cv; // R16
        end
    end
    assign cb.res_v   = res_v_q;
    assign cb.res     = res_q;
    assign cb.lim_ev  = lim_q;
    assign cb.disc_ev = disc_q;
endmodule

// ==== rtl/dcr_top.sv ====
// Overview of operation
// R1 - both channels converted together
// R2 - sampling cycle 20, 40 or 80 us
// R3 - time or moving average, 1 to 1000 samples
// R4 - filter off, low-pass or band-pass
// R5 - log 2000 results and a peak per channel
// R6 - gain, offset, then clip to max and min
// R7 - per channel trigger, rising or falling edge
// R8 - trigger toggles at most 10 kHz
// R9 - disconnect detection only in 4-20 mA, 1-5 V
// R10 - saturate at conversion limits, raise limit error
// R11 - beyond hardware limit: max or min code, error flag
// R12 - error lamp on if serious, blinks if minor
// R13 - conversion lamp blinks while running
// R14 - input lamp lit while input present
// R15 - limit and disconnect flags held until cleared
// R16 - average and filter before calibration
module dcr_top
    import dcr_pkg::*;
#(
    parameter int SMP_CYC = SMP_BASE_CYC,
    parameter int BLINK_N = BLINK_CYC,
    parameter int LOG_N   = LOG_DEPTH
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output wire logic [31:0] wb_dat_o,
    output wire logic        wb_ack_o,
    output wire logic        adc_start,
    input  wire logic        adc_valid,
    input  wire logic [16:0] adc_code0,
    input  wire logic [16:0] adc_code1,
    input  wire logic [1:0]  adc_hi,
    input  wire logic [1:0]  adc_lo,
    input  wire logic [1:0]  trig_in,
    input  wire logic [1:0]  sig_in,
    output wire logic        irq,
    output wire logic        err_led,
    output wire logic        conv_led,
    output wire logic [1:0]  in_led
);
    localparam int BW = $clog2(BLINK_N + 1);
    localparam int LW = $clog2(LOG_N + 1);

    function automatic logic [31:0] bmerge(input logic [31:0] o,
                                           input logic [31:0] n,
                                           input logic [3:0]  s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        return (o & ~m) | (n & m);
    endfunction

    logic [31:0]      ctrl_q, mask_q, dat_q;
    logic [ST_W-1:0]  stat_q;
    logic [31:0]      cfg_q  [NCH];
    logic [31:0]      cal_q  [NCH];
    logic [31:0]      clip_q [NCH];
    logic [31:0]      avg_q  [NCH];
    logic [15:0]      data_q [NCH];
    logic [15:0]      peak_q [NCH];
    logic [LW-1:0]    lcnt_q [NCH];
    logic [11:0]      lidx_q;
    logic [15:0]      ldat_q;
    logic             ack_q;

    // one wait state, every access answered
    wire        go      = wb_cyc_i && wb_stb_i && !ack_q;
    wire        wr      = go && wb_we_i;
    wire        is_ch   = (wb_adr_i[7:6] == A_CHBLK);
    wire        ach     = wb_adr_i[5];
    wire [2:0]  sub     = wb_adr_i[4:2];
    wire        wr_ch   = wr && is_ch;
    wire        wr_stat = wr && (wb_adr_i == A_STAT);
    wire        wr_lcnt = wr && (wb_adr_i == A_LCNT);

    wire run       = ctrl_q[C_RUN];
    wire [1:0] sel = ctrl_q[C_SMP +: 2];
    wire trig_mode = ctrl_q[C_TRIG];
    wire [1:0] edg = ctrl_q[C_EDGE +: 2];
    wire log_en    = ctrl_q[C_LOG];

    // third stage only feeds edge detection
    logic [1:0] t1_q, t2_q, t3_q, s1_q, s2_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            t1_q <= '0;
            t2_q <= '0;
            t3_q <= '0;
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            t1_q <= trig_in;
            t2_q <= t1_q;
            t3_q <= t2_q;
            s1_q <= sig_in;
            s2_q <= s1_q;
        end
    end
    // a 10 kHz trigger is far slower than this resolves
    wire [1:0] rise   = t2_q & ~t3_q;
    wire [1:0] fall   = ~t2_q & t3_q;
    wire [1:0] trg_ev = (edg & fall) | (~edg & rise); // R7

    // sampling timer
    wire [1:0]  sh   = (sel == 2'b00) ? 2'd0 : (sel == 2'b01) ? 2'd1 : 2'd2;
    wire [15:0] per  = 16'(SMP_CYC << sh);                        // R2
    logic [15:0] tmr_q;
    wire tick = run && (tmr_q == per - 16'h0001);
    wire conv_go = run && (trig_mode ? |trg_ev : tick);
    logic start_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tmr_q   <= '0;
            start_q <= 1'b0;
        end else begin
            tmr_q   <= (!run || tick) ? 16'h0000 : tmr_q + 16'h0001;
            start_q <= conv_go; // R1
        end
    end

    // channel processing
    dcr_chan_if cif [NCH] ();
    wire smp = adc_valid && run;
    wire [16:0] codes [NCH];
    assign codes[0] = adc_code0;
    assign codes[1] = adc_code1;
    wire [NCH-1:0] res_v, lim_ev, disc_ev;
    wire [15:0]    res [NCH];
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            assign cif[g].smp_v = smp; // R1
            assign cif[g].clr   = wr_ch && (ach == g) &&
                                  (sub == S_CFG || sub == S_AVG);
            assign cif[g].code  = $signed(codes[g]);
            assign cif[g].hi    = adc_hi[g];
            assign cif[g].lo    = adc_lo[g];
            assign cif[g].cfg   = cfg_q[g];
            assign cif[g].cal   = cal_q[g];
            assign cif[g].clip  = clip_q[g];
            assign cif[g].avg   = avg_q[g];
            assign res_v[g]     = cif[g].res_v;
            assign res[g]       = cif[g].res;
            assign lim_ev[g]    = cif[g].lim_ev;
            assign disc_ev[g]   = cif[g].disc_ev;
            dcr_chan #(
                .AVG_DEPTH (AVG_MAX)
            ) u_chan (
                .clk_sys (clk_sys),
                .rst_b   (rst_b),
                .cb      (cif[g])
            );
        end
    endgenerate

    // byte enables honoured
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= CTRL_RST;
            mask_q <= '0;
            lidx_q <= '0;
        end else begin
            if (wr && wb_adr_i == A_CTRL)
                ctrl_q <= bmerge(ctrl_q, wb_dat_i, wb_sel_i);
            if (wr && wb_adr_i == A_MASK)
                mask_q <= bmerge(mask_q, wb_dat_i, wb_sel_i);
            if (wr && wb_adr_i == A_LIDX)
                lidx_q <= 12'(bmerge({20'h0_0000, lidx_q}, wb_dat_i, wb_sel_i));
        end
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int c = 0; c < NCH; c++) begin
                cfg_q[c]  <= CFG_RST;
                cal_q[c]  <= CAL_RST;
                clip_q[c] <= CLIP_RST;
                avg_q[c]  <= AVG_RST;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (wr_ch && ach == c && sub == S_CFG)
                    cfg_q[c] <= bmerge(cfg_q[c], wb_dat_i, wb_sel_i);
                if (wr_ch && ach == c && sub == S_CAL)
                    cal_q[c] <= bmerge(cal_q[c], wb_dat_i, wb_sel_i);
                if (wr_ch && ach == c && sub == S_CLIP)
                    clip_q[c] <= bmerge(clip_q[c], wb_dat_i, wb_sel_i);
                if (wr_ch && ach == c && sub == S_AVG)
                    avg_q[c] <= bmerge(avg_q[c], wb_dat_i, wb_sel_i);
            end
        end
    end

    // a peak write beats a new sample
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int c = 0; c < NCH; c++) begin
                data_q[c] <= '0;
                peak_q[c] <= PEAK_RST;
                lcnt_q[c] <= '0;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (res_v[c]) data_q[c] <= res[c];
                if (wr_ch && ach == c && sub == S_PEAK)
                    peak_q[c] <= PEAK_RST;
                else if (res_v[c] &&
                         $signed(res[c]) > $signed(peak_q[c]))
                    peak_q[c] <= res[c]; // R5
                if (wr_lcnt)
                    lcnt_q[c] <= '0;
                else if (res_v[c] && log_en && lcnt_q[c] < LW'(LOG_N))
                    lcnt_q[c] <= lcnt_q[c] + 1'b1; // R5
            end
        end
    end

    // logs stop when full; a count clear restarts them
    logic [15:0] log0 [LOG_N];
    logic [15:0] log1 [LOG_N];
    wire [LW-1:0] lrd = lidx_q[LW-1:0];
    always_ff @(posedge clk_sys) begin
        if (res_v[0] && log_en && lcnt_q[0] < LW'(LOG_N))
            log0[lcnt_q[0]] <= res[0]; // R5
        if (res_v[1] && log_en && lcnt_q[1] < LW'(LOG_N))
            log1[lcnt_q[1]] <= res[1]; // R5
        ldat_q <= (lrd >= LW'(LOG_N)) ? 16'h0000 :
                  (lidx_q[LI_CH] ? log1[lrd] : log0[lrd]);
    end

    // a new event beats a write-one clear
    wire [ST_W-1:0] ev  = {|res_v, trg_ev, disc_ev, lim_ev};
    wire [ST_W-1:0] w1c = (wr_stat && wb_sel_i[0]) ?
                          wb_dat_i[ST_W-1:0] : '0;
    logic irq_q;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            stat_q <= '0;
            irq_q  <= 1'b0;
        end else begin
            stat_q <= (stat_q & ~w1c) | ev; // R15
            irq_q  <= |(stat_q & mask_q[ST_W-1:0]);
        end
    end

    // read path
    wire [31:0] ch_rd = (sub == S_CFG)  ? cfg_q[ach]  :
                        (sub == S_CAL)  ? cal_q[ach]  :
                        (sub == S_CLIP) ? clip_q[ach] :
                        (sub == S_AVG)  ? avg_q[ach]  :
                        (sub == S_DATA) ? {16'h0000, data_q[ach]} :
                        (sub == S_PEAK) ? {16'h0000, peak_q[ach]} :
                        32'h0000_0000;
    wire [31:0] gl_rd = (wb_adr_i == A_CTRL) ? ctrl_q :
                        (wb_adr_i == A_STAT) ? 32'(stat_q) :
                        (wb_adr_i == A_MASK) ? mask_q :
                        (wb_adr_i == A_LIDX) ? {20'h0_0000, lidx_q} :
                        (wb_adr_i == A_LDAT) ? {16'h0000, ldat_q} :
                        (wb_adr_i == A_LCNT) ?
                            {5'h00, lcnt_q[1], 5'h00, lcnt_q[0]} :
                        32'h0000_0000;
    wire [31:0] rd = is_ch ? ch_rd : gl_rd;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= go;
            if (go && !wb_we_i) dat_q <= rd;
        end
    end

    // indicators
    logic [BW-1:0] blk_q;
    logic          blink_q, err_q, conv_q;
    logic [1:0]    in_q;
    wire blk_end = (blk_q == BW'(BLINK_N - 1));
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            blk_q   <= '0;
            blink_q <= 1'b0;
            err_q   <= 1'b0;
            conv_q  <= 1'b0;
            in_q    <= '0;
        end else begin
            blk_q   <= blk_end ? '0 : blk_q + 1'b1;
            blink_q <= blk_end ? !blink_q : blink_q;
            err_q   <= (|stat_q[ST_DISC +: 2]) ? 1'b1 :
                       (|stat_q[ST_LIM +: 2]) ? blink_q : 1'b0; // R12
            conv_q  <= run && blink_q;                          // R13
            in_q    <= s2_q;                                    // R14
        end
    end

    assign wb_dat_o  = dat_q;
    assign wb_ack_o  = ack_q;
    assign adc_start = start_q;
    assign irq       = irq_q;
    assign err_led   = err_q;
    assign conv_led  = conv_q;
    assign in_led    = in_q;
endmodule

// ==== testbench/dcr_properties.sv ====
module dcr_properties (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        adc_start,
    input wire logic [1:0]  sig_in,
    input wire logic [1:0]  in_led,
    input wire logic        irq,
    input wire logic        err_led,
    input wire logic        conv_led
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_steady;
        $stable(sig_in) [*6];
    endsequence
    ack_answer_a: assert property (s_req |=> wb_ack_o)
        else $error("no ack");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("long ack");
    ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("stray ack");
    unmapped_zero_a: assert property (s_req ##0
        (!wb_we_i && wb_adr_i == 8'hFC) |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read");
    reset_quiet_a: assert property ($rose(rst_b) |-> in_led == 2'h0 &&
        !(wb_ack_o || adc_start || irq || err_led || conv_led))
        else $error("busy after reset");
    start_pulse_a: assert property (adc_start |=> !adc_start)
        else $error("long start");
    start_gap_a: assert property (adc_start |=> !adc_start [*8])
        else $error("starts too close");
    input_lamp_a: assert property (
        s_steady ##0 $past(rst_b, 8) |-> in_led == sig_in)
        else $error("input lamp wrong");
endmodule

bind dcr_top dcr_properties chk_u (.*);

// ==== testbench/dcr_adc_model.sv ====
module dcr_adc_model (
    input wire logic         clk_sys,
    input wire logic         rst_b,
    input wire logic         adc_start,
    input wire logic [3:0]   lag,
    input wire logic [16:0]  set0,
    input wire logic [16:0]  set1,
    input wire logic [1:0]   set_lo,
    output logic             adc_valid,
    output wire logic [16:0] adc_code0,
    output wire logic [16:0] adc_code1,
    output wire logic [1:0]  adc_hi,
    output wire logic [1:0]  adc_lo
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt_q;
    // garbage outside valid exposes late sampling
    assign adc_code0 = adc_valid ? set0 : ~set0;
    assign adc_code1 = adc_valid ? set1 : ~set1;
    assign adc_hi    = adc_valid ? 2'h0 : 2'h3;
    assign adc_lo    = adc_valid ? set_lo : ~set_lo;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q     <= 5'h0;
            adc_valid <= 1'b0;
        end else begin
            adc_valid <= cnt_q == 5'h1;
            if (adc_start)
                cnt_q <= {1'b0, lag} + 5'h1;
            else if (cnt_q != 5'h0)
                cnt_q <= cnt_q - 5'h1;
        end
    end
endmodule

// ==== testbench/test_dcr_top.sv ====
module test_dcr_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, ack, adc_start, adc_valid, irq, err_led, conv_led;
    logic        rst_b = 1'b0, req = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000, rdat;
    logic [16:0] code0, code1, set0 = 17'h0_0000, set1 = 17'h0_03E8;
    logic [1:0]  hi, lo, in_led, set_lo = 2'h0;
    logic [1:0]  trig_in = 2'h0, sig_in = 2'h0;
    logic [3:0]  lag = 4'h0;
    int          fail_count = 0, checked = 0, nstart = 0;
    dcr_top #(.SMP_CYC(20), .BLINK_N(8), .LOG_N(2000)) dut_u (
        .clk_sys, .rst_b, .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .adc_start, .adc_valid, .adc_code0(code0),
        .adc_code1(code1), .adc_hi(hi), .adc_lo(lo), .trig_in, .sig_in,
        .irq, .err_led, .conv_led, .in_led);
    dcr_adc_model adc_u (.clk_sys, .rst_b, .adc_start, .lag, .set0, .set1,
        .set_lo, .adc_valid, .adc_code0(code0), .adc_code1(code1),
        .adc_hi(hi), .adc_lo(lo));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) nstart += adc_start;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge clk_sys);
        req  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        req <= 1'b0;
        if (n >= 50) check(ack, 1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input logic [31:0] m = 32'hFFFF_FFFF);
        logic [31:0] q;
        wb(1'b0, a, 32'h0000_0000, q);
        check(q & m, e);
    endtask
    // stop after one sample so later ones cannot mask it
    task automatic wait_res();
        int n = 0;
        while (adc_valid !== 1'b1 && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        check(n < 400, 1);
        repeat (8) @(posedge clk_sys);
        wr(8'h00, 32'h0000_0000);
    endtask
    task automatic blink(input logic pick, input logic want);
        int t = 0;
        logic p = pick ? conv_led : err_led;
        repeat (40) begin
            @(posedge clk_sys);
            t += ((pick ? conv_led : err_led) !== p);
            p = pick ? conv_led : err_led;
        end
        check(t > 2, want);
    endtask
    task automatic t_regs();
        rdc(8'h44, 32'h0000_4000);
        rdc(8'h48, 32'h7FFF_8000);
        rdc(8'h4C, 32'h8000_0001);
        rdc(8'hFC, 32'h0000_0000);
        sig_in <= 2'h2;
        repeat (6) @(posedge clk_sys);
        check(in_led, 2'h2);
    endtask
    task automatic t_limit();
        wr(8'h60, 32'h0000_0007);
        wr(8'h08, 32'h0000_0040);
        set0   <= 17'h0_9C40;
        set_lo <= 2'h2;
        wr(8'h00, 32'h0000_0005);
        wait_res();
        rdc(8'h50, 32'h0000_7E80);
        rdc(8'h70, 32'h0000_FE80);
        rdc(8'h54, 32'h0000_7E80);
        rdc(8'h04, 32'h0000_004B);
        check(irq, 1);
        check(err_led, 1);
        blink(1'b0, 1'b0);
        wr(8'h04, 32'h0000_000C);
        blink(1'b0, 1'b1);
        wr(8'h04, 32'h0000_007F);
        rdc(8'h04, 32'h0000_0000);
        check(irq, 0);
    endtask
    task automatic t_cal();
        lag    <= 4'h3;
        set0   <= 17'h0_03E8;
        set_lo <= 2'h0;
        wr(8'h44, 32'h0064_2000);
        wr(8'h48, 32'h026C_8000);
        wr(8'h68, 32'h01F4_8000);
        wr(8'h00, 32'h0000_0041);
        wait_res();
        rdc(8'h50, 32'h0000_0258);
        rdc(8'h70, 32'h0000_01F4);
        rdc(8'h14, 32'h0001_0001);
        rdc(8'h10, 32'h0000_0258);
    endtask
    task automatic t_trig();
        int m;
        trig_in <= 2'h1;
        repeat (5000) @(posedge clk_sys);
        wr(8'h04, 32'h0000_007F);
        wr(8'h00, 32'h0000_0019);
        m = nstart;
        trig_in <= 2'h2;
        repeat (12) @(posedge clk_sys);
        check(nstart - m, 1);
        rdc(8'h04, 32'h0000_0030, 32'h0000_0030);
        blink(1'b1, 1'b1);
        wr(8'h04, 32'h0000_007F);
        repeat (5000) @(posedge clk_sys);
        m = nstart;
        trig_in <= 2'h1;
        repeat (12) @(posedge clk_sys);
        check(nstart - m, 0);
        rdc(8'h04, 32'h0000_0000, 32'h0000_0030);
        wr(8'h00, 32'h0000_0000);
        blink(1'b1, 1'b0);
        check(conv_led, 0);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_regs();
        t_limit();
        t_cal();
        t_trig();
        print_verdict();
    end
    initial begin
        repeat (40000) @(posedge clk_sys);
        fail_count++;
        print_verdict();
    end
endmodule
